// >>> old_core.sv
// Output logic combiner, per-output transition delays, fault-clear handling and APB register file.
`timescale 1ns/1ps

// How it works
// - Each combiner operand is chosen independently from nine internal status inputs.
// - Operator code 00 is AND, 01 is OR, 02 is XOR.
// - Combined status follows the standard AND, OR and XOR truth tables.
// - Terminal 1, terminal 2 or relay may each take the combined status as source.
// - After reset operand A selects code 00, operand B code 01, operator 00.
// - Each of the three outputs has its own rise delay and fall delay.
// - Delays span 0.0 to 100.0 s in 0.1 s steps; zero means no delay.
// - Without fall delay, fault clear turns motor and status outputs off together.
// - With a fall delay, an output stays on about one more second after fault clear.
// - Response 00 cancels trip on fault-clear rise and stops a running drive.
// - Response 01 cancels trip on fault-clear fall and stops a running drive.
// - Response 02 cancels trip on fault-clear rise and leaves a running drive alone.
module old_core #(
    parameter int TICK_CYCLES = old_pkg::TICK_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [8:0]  status_in,
    input  wire logic        fault_clear_terminal_in,
    input  wire logic        trip_set_in,
    input  wire logic        drive_running_in,
    output logic             term1_out,
    output logic             term2_out,
    output logic             relay_out,
    output logic             motor_off_out,
    output logic             trip_out,
    output logic             stop_drive_out
);

    localparam int TW = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Register file over APB.
    old_pkg::old_ctrl_s   ctrl_r;
    old_pkg::old_ctrl_s   ctrl_nxt;
    old_pkg::old_assign_s asg_r;
    old_pkg::old_assign_s asg_nxt;
    logic [9:0]           dly_r [old_pkg::NUM_DLY];
    logic [9:0]           dly_nxt [old_pkg::NUM_DLY];
    logic [31:0]          rdata_r;
    logic [31:0]          rdata_nxt;
    logic [31:0]          rsel;
    logic                 wr_acc;
    logic                 hit;
    logic                 log_r;
    logic                 log_nxt;
    logic [2:0]           pin_r;
    logic                 trip_r;
    logic                 fc_s2;
    logic [9:0]           wdly;

    assign wr_acc      = psel_in && penable_in && pwrite_in;
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !hit;
    assign prdata_out  = rdata_r;
    // Writes above the top of range are clamped, since larger counts are not a valid setting.
    assign wdly        = (pwdata_in > 32'(old_pkg::DLY_MAX)) ? old_pkg::DLY_MAX : pwdata_in[9:0];

    always_comb begin
        ctrl_nxt  = ctrl_r;
        asg_nxt   = asg_r;
        rdata_nxt = rdata_r;
        rsel      = 32'h0000_0000;
        hit       = 1'b0;
        for (int k = 0; k < old_pkg::NUM_DLY; k++) begin
            dly_nxt[k] = dly_r[k];
            if (paddr_in == old_pkg::ADDR_DLY0 + 8'(4 * k)) begin
                hit        = 1'b1;
                rsel[9:0]  = dly_r[k];
                dly_nxt[k] = wr_acc ? wdly : dly_r[k];
            end
        end
        if (paddr_in == old_pkg::ADDR_CTRL) begin
            hit        = 1'b1;
            rsel[11:0] = ctrl_r;
            ctrl_nxt   = wr_acc ? old_pkg::old_ctrl_s'(pwdata_in[11:0]) : ctrl_r;
        end
        if (paddr_in == old_pkg::ADDR_ASSIGN) begin
            hit        = 1'b1;
            rsel[11:0] = asg_r;
            asg_nxt    = wr_acc ? old_pkg::old_assign_s'(pwdata_in[11:0]) : asg_r;
        end
        if (paddr_in == old_pkg::ADDR_STATUS) begin
            hit        = 1'b1;
            rsel[14:0] = {trip_r, fc_s2, pin_r, log_r, status_in};
        end
        // Read data is captured in the setup cycle so it stands from a flip-flop in the access cycle.
        if (psel_in && !penable_in) begin
            rdata_nxt = rsel;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_r  <= old_pkg::CTRL_RST;
            asg_r   <= old_pkg::ASSIGN_DEF;
            rdata_r <= 32'h0000_0000;
            for (int k = 0; k < old_pkg::NUM_DLY; k++) begin
                dly_r[k] <= old_pkg::DLY_ZERO;
            end
        end else begin
            ctrl_r  <= ctrl_nxt;
            asg_r   <= asg_nxt;
            rdata_r <= rdata_nxt;
            for (int k = 0; k < old_pkg::NUM_DLY; k++) begin
                dly_r[k] <= dly_nxt[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Combiner. Selections beyond the nine sources read as low.
    logic opa_v;
    logic opb_v;

    assign opa_v = (ctrl_r.opa < 4'(old_pkg::NUM_SRC)) ? status_in[ctrl_r.opa] : 1'b0;
    assign opb_v = (ctrl_r.opb < 4'(old_pkg::NUM_SRC)) ? status_in[ctrl_r.opb] : 1'b0;

    always_comb begin
        unique case (ctrl_r.op)
            old_pkg::OP_AND: log_nxt = opa_v & opb_v;
            old_pkg::OP_OR:  log_nxt = opa_v | opb_v;
            old_pkg::OP_XOR: log_nxt = opa_v ^ opb_v;
            default:         log_nxt = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault-clear pin synchroniser, tick and trip state.
    logic          fc_s1;
    logic          fc_d_r;
    logic          fc_rise;
    logic          fc_fall;
    logic [TW-1:0] tick_r;
    logic [TW-1:0] tick_nxt;
    logic          tick;
    logic          cancel;
    logic          trip_nxt;
    logic          stop_nxt;

    assign fc_rise = fc_s2 && !fc_d_r;
    assign fc_fall = !fc_s2 && fc_d_r;
    assign tick    = (tick_r == TICK_LAST);

    always_comb begin
        tick_nxt = tick ? '0 : tick_r + 1'b1;
        cancel   = (ctrl_r.fc_resp == old_pkg::FC_FALL_STOP) ? fc_fall : fc_rise;
        stop_nxt = cancel && drive_running_in && (ctrl_r.fc_resp != old_pkg::FC_RISE_ONLY);
        trip_nxt = cancel ? 1'b0 : trip_r;
        // A trip that arrives with the cancelling edge survives it.
        if (trip_set_in) begin
            trip_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fc_s1  <= 1'b0;
            fc_s2  <= 1'b0;
            fc_d_r <= 1'b0;
            tick_r <= '0;
            trip_r <= 1'b0;
            log_r  <= 1'b0;
            stop_drive_out <= 1'b0;
            motor_off_out  <= 1'b0;
        end else begin
            fc_s1  <= fault_clear_terminal_in;
            fc_s2  <= fc_s1;
            fc_d_r <= fc_s2;
            tick_r <= tick_nxt;
            trip_r <= trip_nxt;
            log_r  <= log_nxt;
            stop_drive_out <= stop_nxt;
            motor_off_out  <= fc_d_r;
        end
    end

    assign trip_out = trip_r;

    ////////////////////////////////////////////////////////////////////////////
    // Output channels: 0 is terminal 1, 1 is terminal 2, 2 is the relay.
    logic [3:0] asg_v [old_pkg::NUM_CHAN];
    logic [2:0] src;
    logic [2:0] lvl_r;
    logic [2:0] lvl_nxt;
    logic [2:0] pend_r;
    logic [2:0] pend_nxt;
    logic [9:0] cnt_r [old_pkg::NUM_CHAN];
    logic [9:0] cnt_nxt [old_pkg::NUM_CHAN];
    logic [2:0] force_r;
    logic [2:0] force_nxt;
    logic [2:0] hold_r;
    logic [2:0] hold_nxt;
    logic [3:0] hcnt_r [old_pkg::NUM_CHAN];
    logic [3:0] hcnt_nxt [old_pkg::NUM_CHAN];
    logic [9:0] sel_dly [old_pkg::NUM_CHAN];

    assign asg_v[0] = asg_r.term1;
    assign asg_v[1] = asg_r.term2;
    assign asg_v[2] = asg_r.relay;

    always_comb begin
        for (int i = 0; i < old_pkg::NUM_CHAN; i++) begin
            if (asg_v[i] == old_pkg::SEL_LOG) begin
                src[i] = log_r;
            end else if (asg_v[i] < 4'(old_pkg::NUM_SRC)) begin
                src[i] = status_in[asg_v[i]];
            end else begin
                src[i] = 1'b0;
            end
            sel_dly[i]  = src[i] ? dly_r[2 * i] : dly_r[2 * i + 1];
            lvl_nxt[i]  = lvl_r[i];
            pend_nxt[i] = pend_r[i];
            cnt_nxt[i]  = cnt_r[i];
            if (src[i] == lvl_r[i]) begin
                pend_nxt[i] = 1'b0;
            end else if (!pend_r[i]) begin
                if (sel_dly[i] == old_pkg::DLY_ZERO) begin
                    lvl_nxt[i] = src[i];
                end else begin
                    pend_nxt[i] = 1'b1;
                    cnt_nxt[i]  = sel_dly[i];
                end
            end else if (tick) begin
                if (cnt_r[i] == 10'h001) begin
                    lvl_nxt[i]  = src[i];
                    pend_nxt[i] = 1'b0;
                end
                cnt_nxt[i] = cnt_r[i] - 10'h001;
            end
            // Fault clear forces the output off, after a hold when a fall delay is set.
            force_nxt[i] = force_r[i];
            hold_nxt[i]  = hold_r[i];
            hcnt_nxt[i]  = hcnt_r[i];
            if (!fc_s2) begin
                force_nxt[i] = 1'b0;
                hold_nxt[i]  = 1'b0;
            end else if (fc_rise) begin
                if (dly_r[2 * i + 1] == old_pkg::DLY_ZERO) begin
                    force_nxt[i] = 1'b1;
                end else begin
                    hold_nxt[i] = 1'b1;
                    hcnt_nxt[i] = old_pkg::HOLD_TICKS;
                end
            end else if (hold_r[i] && tick) begin
                if (hcnt_r[i] == 4'h1) begin
                    force_nxt[i] = 1'b1;
                    hold_nxt[i]  = 1'b0;
                end
                hcnt_nxt[i] = hcnt_r[i] - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            lvl_r   <= 3'h0;
            pend_r  <= 3'h0;
            force_r <= 3'h0;
            hold_r  <= 3'h0;
            pin_r   <= 3'h0;
            for (int i = 0; i < old_pkg::NUM_CHAN; i++) begin
                cnt_r[i]  <= 10'h000;
                hcnt_r[i] <= 4'h0;
            end
        end else begin
            lvl_r   <= lvl_nxt;
            pend_r  <= pend_nxt;
            force_r <= force_nxt;
            hold_r  <= hold_nxt;
            pin_r   <= lvl_r & ~force_r;
            for (int i = 0; i < old_pkg::NUM_CHAN; i++) begin
                cnt_r[i]  <= cnt_nxt[i];
                hcnt_r[i] <= hcnt_nxt[i];
            end
        end
    end

    assign term1_out = pin_r[0];
    assign term2_out = pin_r[1];
    assign relay_out = pin_r[2];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    reset_defaults_a: assert property ($past(sys_rst_in) |-> ctrl_r == old_pkg::CTRL_RST)
        else $error("Operand or operator default wrong after reset.");
    and_comb_a: assert property (ctrl_r.op == old_pkg::OP_AND |=> log_r == ($past(opa_v) & $past(opb_v)))
        else $error("AND result wrong.");
    xor_comb_a: assert property (ctrl_r.op == old_pkg::OP_XOR |=> log_r == ($past(opa_v) != $past(opb_v)))
        else $error("XOR result wrong.");
    operand_sel_a: assert property (ctrl_r.opa == 4'h3 |-> opa_v == status_in[3])
        else $error("Operand A does not follow its selected source.");
    route_log_a: assert property (asg_r.relay == old_pkg::SEL_LOG |-> src[2] == log_r)
        else $error("Relay does not take the combined status.");
    zero_delay_a: assert property (src[0] != lvl_r[0] && !pend_r[0] && sel_dly[0] == old_pkg::DLY_ZERO
                                   |=> lvl_r[0] == $past(src[0]) ##1 pin_r[0] == ($past(src[0], 2) && !$past(force_r[0])))
        else $error("Zero delay did not pass the transition at once.");
    cancel_pend_a: assert property (pend_r[0] && src[0] == lvl_r[0] |=> !pend_r[0] && lvl_r[0] == $past(lvl_r[0]))
        else $error("Returned source did not cancel the pending transition.");
    delay_hold_a: assert property (pend_r[0] && !tick |=> lvl_r[0] == $past(lvl_r[0]))
        else $error("Delayed output changed between ticks.");
    fc_off_a: assert property (fc_rise && dly_r[1] == old_pkg::DLY_ZERO |=> force_r[0] ##1 !pin_r[0] && motor_off_out)
        else $error("Fault clear did not turn terminal 1 off at once.");
    fc_hold_a: assert property (fc_rise && dly_r[5] != old_pkg::DLY_ZERO |=> !force_r[2] && hold_r[2])
        else $error("Relay did not hold after fault clear.");
    trip_rise_a: assert property (fc_rise && trip_r && !trip_set_in && ctrl_r.fc_resp == old_pkg::FC_RISE_STOP
                                  |=> !trip_r)
        else $error("Trip not cancelled on fault-clear rise.");
    trip_fall_a: assert property (fc_rise && ctrl_r.fc_resp == old_pkg::FC_FALL_STOP |=> !stop_drive_out)
        else $error("Fall response acted on the rising edge.");
    no_stop_a: assert property (ctrl_r.fc_resp == old_pkg::FC_RISE_ONLY |=> !stop_drive_out)
        else $error("Response 02 stopped a running drive.");
    tick_period_a: assert property (tick |=> !tick [*2])
        else $error("Tick came twice too close.");

    delayed_rise_c: cover property (pend_r[0] && tick && cnt_r[0] == 10'h001);
    cancel_c: cover property (pend_r[2] ##1 !pend_r[2] && lvl_r[2] == $past(lvl_r[2]));
    fc_hold_c: cover property (hold_r[0] && tick && hcnt_r[0] == 4'h1);
    stop_c: cover property (stop_drive_out && !trip_r);

endmodule

// >>> old_ext_equip.sv
// Model of the external equipment that drives the fault-clear pin and watches the output terminals.
`timescale 1ns/1ps

module old_ext_equip (
    input  wire logic        clk_in,
    input  wire logic        fc_req_in,
    input  wire logic        term1_in,
    input  wire logic        term2_in,
    input  wire logic        relay_in,
    output logic             fault_clear_out,
    output logic      [15:0] toggles_out
);
    logic [2:0] last_r;

    // A contact closure reaches the pin one clock after it is requested, as a switch would.
    initial begin
        fault_clear_out = 1'b0;
        toggles_out     = 16'h0000;
        last_r          = 3'h0;
    end

    always @(posedge clk_in) begin
        fault_clear_out <= fc_req_in;
        last_r          <= {relay_in, term2_in, term1_in};
        if ({relay_in, term2_in, term1_in} !== last_r) begin
            toggles_out <= toggles_out + 16'h0001;
        end
    end
endmodule

// >>> old_pkg.sv
// Package with the register map, field layouts, codes and timing constants of the output logic and delay block.
package old_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the APB port.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_ASSIGN = 8'h04;
    localparam logic [7:0] ADDR_DLY0   = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam int         NUM_DLY     = 6;
    localparam int         NUM_CHAN    = 3;
    localparam int         NUM_SRC     = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Field layouts and reset values.
    localparam int         SEL_W       = 4;
    localparam int         DLY_W       = 10;
    localparam logic [3:0] SEL_LOG     = 4'h9;
    localparam logic [9:0] DLY_MAX     = 10'h3E8;
    localparam logic [9:0] DLY_ZERO    = 10'h000;
    localparam logic [3:0] OPA_RST     = 4'h0;
    localparam logic [3:0] OPB_RST     = 4'h1;
    localparam logic [3:0] ASSIGN_RST  = 4'h0;

    typedef enum logic [1:0] {
        OP_AND = 2'h0,
        OP_OR  = 2'h1,
        OP_XOR = 2'h2
    } old_op_e;

    typedef enum logic [1:0] {
        FC_RISE_STOP = 2'h0,
        FC_FALL_STOP = 2'h1,
        FC_RISE_ONLY = 2'h2
    } old_fc_e;

    typedef struct packed {
        logic [1:0] fc_resp;
        logic [1:0] op;
        logic [3:0] opb;
        logic [3:0] opa;
    } old_ctrl_s;

    typedef struct packed {
        logic [3:0] relay;
        logic [3:0] term2;
        logic [3:0] term1;
    } old_assign_s;

    localparam old_ctrl_s   CTRL_RST   = '{fc_resp: 2'h0, op: 2'h0, opb: OPB_RST, opa: OPA_RST};
    localparam old_assign_s ASSIGN_DEF = '{relay: ASSIGN_RST, term2: ASSIGN_RST, term1: ASSIGN_RST};

    ////////////////////////////////////////////////////////////////////////////
    // Timing: a 0.1 s tick from the 50 MHz clock, and a 1 s hold after fault clear.
    localparam longint CLK_PERIOD_NS  = 20;
    localparam longint TICK_PERIOD_NS = 100000000;
    localparam int     TICK_CYCLES    = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
    localparam longint HOLD_TIME_NS   = 1000000000;
    localparam logic [3:0] HOLD_TICKS = 4'(HOLD_TIME_NS / TICK_PERIOD_NS);

endpackage

// >>> tb_top.sv
// Self-checking testbench of the output logic and delay block.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
    localparam int TICK = 10;
    logic        clk_in;
    logic        sys_rst_in;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [8:0]  status;
    logic        fc_req;
    logic        fc_pin;
    logic        trip_set;
    logic        running;
    logic        term1;
    logic        term2;
    logic        relay;
    logic        motor_off;
    logic        trip;
    logic        stop_drive;
    int          fail_count;
    int          total_checks;
    int          stops;

    old_core #(.TICK_CYCLES(TICK)) i_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .status_in(status),
        .fault_clear_terminal_in(fc_pin), .trip_set_in(trip_set), .drive_running_in(running),
        .term1_out(term1), .term2_out(term2), .relay_out(relay), .motor_off_out(motor_off),
        .trip_out(trip), .stop_drive_out(stop_drive)
    );

    old_ext_equip i_equip (
        .clk_in(clk_in), .fc_req_in(fc_req), .term1_in(term1), .term2_in(term2),
        .relay_in(relay), .fault_clear_out(fc_pin), .toggles_out()
    );

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (stop_drive === 1'b1) begin
            stops <= stops + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // The master never assumes zero wait states; only the watchdog ends a wait that never completes.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK(r, exp)
        `CHK(e, exp_err)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        `CHK({term1, term2, relay, motor_off, trip, stop_drive}, 6'h00)
        rdchk(old_pkg::ADDR_CTRL, 32'h0000_0010, 1'b0);
        rdchk(old_pkg::ADDR_ASSIGN, 32'h0000_0000, 1'b0);
        for (int i = 0; i < 6; i++) begin
            rdchk(old_pkg::ADDR_DLY0 + 8'(4 * i), 32'h0000_0000, 1'b0);
        end
        wr(8'h24, 32'h0000_0FFF);
        rdchk(8'h24, 32'h0000_0000, 1'b1);
        wr(old_pkg::ADDR_DLY0, 32'h0000_03E9);
        rdchk(old_pkg::ADDR_DLY0, 32'h0000_03E8, 1'b0);
        wr(old_pkg::ADDR_DLY0, 32'h0000_07D0);
        rdchk(old_pkg::ADDR_DLY0, 32'h0000_03E8, 1'b0);
        wr(old_pkg::ADDR_DLY0, 32'h0000_0000);
    endtask

    // Every operand select meets every operator over the full truth table; the spare operator code must read low.
    task automatic t_logic;
        int          b;
        logic        va;
        logic        vb;
        logic        exp;
        old_pkg::old_ctrl_s c;
        wr(old_pkg::ADDR_ASSIGN, 32'h0000_0999);
        for (int op = 0; op < 4; op++) begin
            for (int k = 0; k < 9; k++) begin
                b = (k + 4) % 9;
                c = '{fc_resp: 2'h0, op: 2'(op), opb: 4'(b), opa: 4'(k)};
                wr(old_pkg::ADDR_CTRL, 32'(c));
                for (int ab = 0; ab < 4; ab++) begin
                    va = ab[1];
                    vb = ab[0];
                    exp = (op == 0) ? (va & vb) : (op == 1) ? (va | vb) : (op == 2) ? (va ^ vb) : 1'b0;
                    @(posedge clk_in);
                    status <= (9'(va) << k) | (9'(vb) << b);
                    cyc(6);
                    `CHK({term1, term2, relay}, {3{exp}})
                end
            end
        end
        wr(old_pkg::ADDR_CTRL, 32'h0000_0010);
    endtask

    task automatic t_delay;
        wr(old_pkg::ADDR_ASSIGN, 32'h0000_0000);
        wr(old_pkg::ADDR_DLY0, 32'h0000_0003);
        @(posedge clk_in);
        status <= 9'h001;
        cyc(15);
        `CHK(term1, 1'b0)
        `CHK(term2, 1'b1)
        cyc(21);
        `CHK(term1, 1'b1)
        status <= 9'h000;
        cyc(5);
        `CHK(term1, 1'b0)
        status <= 9'h001;
        cyc(12);
        status <= 9'h000;
        cyc(40);
        `CHK(term1, 1'b0)
        wr(old_pkg::ADDR_DLY0, 32'h0000_0000);
    endtask

    // The relay carries a fall delay, so it must outlast terminal 1 by the fixed hold.
    task automatic t_fault;
        wr(old_pkg::ADDR_DLY0 + 8'h14, 32'h0000_0005);
        @(posedge clk_in);
        status <= 9'h001;
        cyc(8);
        `CHK({term1, relay}, 2'b11)
        fc_req <= 1'b1;
        cyc(6);
        `CHK({term1, motor_off}, 2'b01)
        `CHK(relay, 1'b1)
        cyc(80);
        `CHK(relay, 1'b1)
        cyc(30);
        `CHK(relay, 1'b0)
        fc_req <= 1'b0;
        cyc(8);
        `CHK({term1, relay, motor_off}, 3'b110)
        rdchk(old_pkg::ADDR_STATUS, 32'h0000_1C01, 1'b0);
        status <= 9'h000;
        cyc(30);
        `CHK({term1, relay}, 2'b01)
        cyc(26);
        `CHK(relay, 1'b0)
    endtask

    task automatic t_modes;
        int s0;
        for (int m = 0; m < 4; m++) begin
            wr(old_pkg::ADDR_CTRL, 32'h0000_0010 | (32'(m) << 10));
            @(posedge clk_in);
            trip_set <= 1'b1;
            running  <= 1'b1;
            @(posedge clk_in);
            trip_set <= 1'b0;
            cyc(3);
            `CHK(trip, 1'b1)
            s0 = stops;
            fc_req <= 1'b1;
            cyc(8);
            `CHK(trip, (m == 1))
            fc_req <= 1'b0;
            cyc(8);
            `CHK(trip, 1'b0)
            `CHK(stops - s0, (m == 2) ? 0 : 1)
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks=%0d errors=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        stop_test();
    end

    initial begin
        fail_count   = 0;
        total_checks = 0;
        stops        = 0;
        sys_rst_in   = 1'b1;
        {psel, penable, pwrite, fc_req, trip_set, running} = 6'h00;
        paddr  = 8'h00;
        pwdata = 32'h0000_0000;
        status = 9'h000;
        cyc(4);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_logic();
        t_delay();
        t_fault();
        t_modes();
        stop_test();
    end
endmodule
